// ==== inc/tsm_pkg.sv ====
// constants, field layouts and types of the timer slave-mode controller
package tsm_pkg;

   // ----------------------------------------------------------------
   // register map (byte addresses)
   // ----------------------------------------------------------------
   localparam logic [7:0]  TSM_CTRL_OFS    = 8'h00;
   localparam logic [7:0]  TSM_SMCFG_OFS   = 8'h08;
   localparam logic [7:0]  TSM_DIE_OFS     = 8'h0c;
   localparam logic [7:0]  TSM_FLAG_OFS    = 8'h10;
   localparam logic [7:0]  TSM_CNT_OFS     = 8'h24;
   localparam logic [7:0]  TSM_RELOAD_OFS  = 8'h2c;

   // ----------------------------------------------------------------
   // reset values and writable masks
   // ----------------------------------------------------------------
   localparam logic [31:0] TSM_REG_RST     = 32'h0000_0000;
   localparam logic [15:0] TSM_RELOAD_RST  = 16'hffff;
   localparam logic [31:0] TSM_DIE_MASK    = 32'h0000_7fff;
   localparam logic [31:0] TSM_FLAG_MASK   = 32'h0000_1eff;

   // ----------------------------------------------------------------
   // field positions
   // ----------------------------------------------------------------
   localparam int          TSM_CEN_BIT     = 0;
   localparam int          TSM_DEN_LSB     = 8;
   localparam int          TSM_OVC_LSB     = 9;
   localparam int          TSM_TRG_FLAG    = 6;
   localparam int          TSM_UPD_FLAG    = 0;

   // ----------------------------------------------------------------
   // counts
   // ----------------------------------------------------------------
   localparam int          TSM_SYNC_W      = 7;
   localparam logic [4:0]  TSM_DTS_DIV     = 5'h01;

   typedef enum logic [2:0] {
      TSM_SMC_DISABLE, TSM_SMC_QUAD0, TSM_SMC_QUAD1, TSM_SMC_QUAD2,
      TSM_SMC_RESTART, TSM_SMC_PAUSE, TSM_SMC_EVENT, TSM_SMC_EXTCLK0
   } tsm_smc_t;

   typedef enum logic [2:0] {
      TSM_TRG_ITR0, TSM_TRG_ITR1, TSM_TRG_ITR2, TSM_TRG_ITR3,
      TSM_TRG_CH0ED, TSM_TRG_CH0F, TSM_TRG_CH1F, TSM_TRG_EXTF
   } tsm_trigger_select_t;

   // slave mode configuration word, bit 15 down to bit 0
   typedef struct packed {
      logic       ext_polarity;
      logic       ext_clk_mode1;
      logic [1:0] ext_prescale;
      logic [3:0] ext_trigger_filter_code;
      logic       master_slave_sync;
      tsm_trigger_select_t  trigger_select;
      logic       rsvd3;
      tsm_smc_t   slave_mode_control;
   } tsm_smcfg_t;

   // per-channel event pulses from the capture/compare channels
   typedef struct packed {
      logic [3:0] capture;
      logic [3:0] compare;
   } tsm_chan_ev_t;

   // filter code to required sample count
   function automatic logic [3:0] tsm_filt_count(input logic [3:0] code);
      logic [3:0] n;
      n = 4'h8;
      case (code)
         4'h1: n = 4'h2;
         4'h2: n = 4'h4;
         4'h4, 4'h6, 4'h8, 4'hb, 4'he: n = 4'h6;
         4'ha, 4'hd: n = 4'h5;
         default: n = 4'h8;
      endcase
      return n;
   endfunction

   // filter code to sampling divider of the dead-time clock (1 = timer clock)
   function automatic logic [5:0] tsm_filt_div(input logic [3:0] code);
      logic [5:0] d;
      d = 6'h01;
      case (code)
         4'h4, 4'h5: d = 6'h02;
         4'h6, 4'h7: d = 6'h04;
         4'h8, 4'h9: d = 6'h08;
         4'ha, 4'hb, 4'hc: d = 6'h10;
         4'hd, 4'he, 4'hf: d = 6'h20;
         default: d = 6'h01;
      endcase
      return d;
   endfunction

endpackage

// ==== design/tsm_slave_ctrl.sv ====
// slave-mode controller, counter, enable and flag registers of a timer
`timescale 1ns/100ps

// What this block does
// R1 - master-slave sync set: trigger events go out on trigger_output instead of update events
// R2 - trigger_select picks internal triggers 0-3, chan0 edge, chan0, chan1, ext trigger
// R3 - software leaves trigger_select alone while a slave mode is active
// R4 - mode 000: no slave mode, counter runs on timer clock while enabled
// R5 - mode 001: count on chan0 edges, direction from chan1 level
// R6 - mode 010: count on chan1 edges, direction from chan0 level
// R7 - mode 011: count on both channels' edges, each giving the other's direction
// R8 - mode 100: trigger rising edge reinitialises counter and makes update event
// R9 - mode 101: counter clock enabled while trigger is high, gated while low
// R10 - mode 110: trigger rising edge sets counter enable
// R11 - mode 111: counter advances once per trigger rising edge
// R12 - one DMA enable bit per source at bits 14 to 8
// R13 - one interrupt enable bit per source at bits 7 to 0
// R14 - enable register at 0x0c, resets to zero, bits 31:15 reserved
// R15 - flag register at 0x10, flags cleared by writing zero
// R16 - software uses word accesses and writes reserved bits as zero
// R17 - ext trigger filter accepts a level seen N times; code 0 bypasses
// R18 - update flag set on every update event until software clears it
// R19 - over-capture flag set when capture hits an already set channel flag
// R20 - pause mode makes trigger events on both edges, else rising only
// R21 - filter code selects sample count and sample rate from the table
// R22 - interrupt while enabled flag set; DMA request on enabled source event
module tsm_slave_ctrl (
   // clock and reset
   input  wire  logic                mclk,
   input  wire  logic                rst_n,
   // apb slave
   input  wire  logic                psel,
   input  wire  logic                penable,
   input  wire  logic                pwrite,
   input  wire  logic [7:0]          paddr,
   input  wire  logic [31:0]         pwdata,
   output logic                      pready,
   output logic [31:0]               prdata,
   output logic                      pslverr,
   // asynchronous trigger and channel inputs
   input  wire  logic [3:0]          internal_trigger,
   input  wire  logic                chan0_filtered_in,
   input  wire  logic                chan1_filtered_in,
   input  wire  logic                ext_trigger_pin,
   // same-clock events from channel, break and commutation logic
   input  wire  tsm_pkg::tsm_chan_ev_t chan_ev,
   input  wire  logic                break_evt,
   input  wire  logic                commutation_evt,
   // outputs
   output logic                      trigger_output,
   output logic                      irq_req,
   output logic [6:0]                dma_req,
   output logic [15:0]               count_value
);
   import tsm_pkg::*;

   // ----------------------------------------------------------------
   // state
   // ----------------------------------------------------------------
   tsm_smcfg_t               smcfg_r;
   logic [31:0]              die_r;
   logic [31:0]              flags_r;
   logic                     cen_r;
   logic [15:0]              cnt_r;
   logic [15:0]              reload_r;
   logic [TSM_SYNC_W-1:0]    s1_r, s2_r, s3_r, pin_r;
   logic                     trig_prev_r, ch0_prev_r, ch1_prev_r, ext_prev_r;
   logic [2:0]               psc_r;
   logic                     filt_out_r;
   logic [3:0]               filt_cnt_r;
   logic [5:0]               samp_cnt_r;
   logic [4:0]               dts_cnt_r;

   // ----------------------------------------------------------------
   // input synchronisers
   // ----------------------------------------------------------------
   logic [TSM_SYNC_W-1:0]    pin_raw;
   assign pin_raw = {ext_trigger_pin, chan1_filtered_in, chan0_filtered_in, internal_trigger};

   genvar g;
   generate
      for (g = 0; g < TSM_SYNC_W; g++) begin : g_sync
         always_ff @(posedge mclk or negedge rst_n) begin
            if (!rst_n) begin
               s1_r[g]  <= 1'b0;
               s2_r[g]  <= 1'b0;
               s3_r[g]  <= 1'b0;
               pin_r[g] <= 1'b0;
            end else begin
               s1_r[g] <= pin_raw[g];
               s2_r[g] <= s1_r[g];
               s3_r[g] <= s2_r[g];
               // accept a change once the later two stages agree
               if (s2_r[g] == s3_r[g]) begin
                  pin_r[g] <= s3_r[g];
               end
            end
         end
      end
   endgenerate

   logic ch0, ch1, ext_pol;
   assign ch0     = pin_r[4];
   assign ch1     = pin_r[5];
   assign ext_pol = pin_r[6] ^ smcfg_r.ext_polarity;

   // ----------------------------------------------------------------
   // external trigger prescaler and filter
   // ----------------------------------------------------------------
   logic ext_psc;
   always_comb begin
      case (smcfg_r.ext_prescale)
         2'h0:    ext_psc = ext_pol;
         2'h1:    ext_psc = psc_r[0];
         2'h2:    ext_psc = psc_r[1];
         default: ext_psc = psc_r[2];
      endcase
   end

   always_ff @(posedge mclk or negedge rst_n) begin
      if (!rst_n) begin
         ext_prev_r <= 1'b0;
         psc_r      <= 3'h0;
      end else begin
         ext_prev_r <= ext_pol;
         if (ext_pol && !ext_prev_r) begin
            psc_r <= psc_r + 3'h1;
         end
      end
   end

   logic [3:0] filt_need;
   logic [5:0] filt_div;
   logic       dts_tick, samp_en;
   assign filt_need = tsm_filt_count(smcfg_r.ext_trigger_filter_code);   // R21
   assign filt_div  = tsm_filt_div(smcfg_r.ext_trigger_filter_code);     // R21
   assign dts_tick  = (dts_cnt_r == TSM_DTS_DIV - 5'h01);
   assign samp_en   = (filt_div == 6'h01) ? 1'b1 : (dts_tick && samp_cnt_r == filt_div - 6'h01);

   // dead-time clock as a tick divided down from the timer clock
   always_ff @(posedge mclk or negedge rst_n) begin
      if (!rst_n) begin
         dts_cnt_r  <= 5'h00;
         samp_cnt_r <= 6'h00;
      end else begin
         dts_cnt_r <= dts_tick ? 5'h00 : dts_cnt_r + 5'h01;
         if (dts_tick) begin
            samp_cnt_r <= (samp_cnt_r >= filt_div - 6'h01) ? 6'h00 : samp_cnt_r + 6'h01;
         end
      end
   end

   always_ff @(posedge mclk or negedge rst_n) begin
      if (!rst_n) begin
         filt_out_r <= 1'b0;
         filt_cnt_r <= 4'h0;
      end else if (smcfg_r.ext_trigger_filter_code == 4'h0) begin
         filt_out_r <= ext_psc;                                          // R17
         filt_cnt_r <= 4'h0;
      end else if (ext_psc == filt_out_r) begin
         filt_cnt_r <= 4'h0;
      end else if (samp_en) begin
         if (filt_cnt_r + 4'h1 >= filt_need) begin
            filt_out_r <= ext_psc;                                       // R17
            filt_cnt_r <= 4'h0;
         end else begin
            filt_cnt_r <= filt_cnt_r + 4'h1;
         end
      end
   end

   // ----------------------------------------------------------------
   // trigger selection and edges
   // ----------------------------------------------------------------
   logic trig_lvl, trig_rise, trig_fall, trig_evt, ch0_edge, ch1_edge;
   assign ch0_edge = ch0 ^ ch0_prev_r;
   assign ch1_edge = ch1 ^ ch1_prev_r;

   // R3: selection is assumed steady while a slave mode is active
   always_comb begin
      case (smcfg_r.trigger_select)                                     // R2
         TSM_TRG_ITR0:  trig_lvl = pin_r[0];
         TSM_TRG_ITR1:  trig_lvl = pin_r[1];
         TSM_TRG_ITR2:  trig_lvl = pin_r[2];
         TSM_TRG_ITR3:  trig_lvl = pin_r[3];
         TSM_TRG_CH0ED: trig_lvl = ch0_edge;
         TSM_TRG_CH0F:  trig_lvl = ch0;
         TSM_TRG_CH1F:  trig_lvl = ch1;
         default:       trig_lvl = filt_out_r;
      endcase
   end

   assign trig_rise = trig_lvl && !trig_prev_r;
   assign trig_fall = !trig_lvl && trig_prev_r;
   assign trig_evt  = (smcfg_r.slave_mode_control == TSM_SMC_PAUSE) ?
                      (trig_rise || trig_fall) : trig_rise;               // R20

   always_ff @(posedge mclk or negedge rst_n) begin
      if (!rst_n) begin
         trig_prev_r <= 1'b0;
         ch0_prev_r  <= 1'b0;
         ch1_prev_r  <= 1'b0;
      end else begin
         trig_prev_r <= trig_lvl;
         ch0_prev_r  <= ch0;
         ch1_prev_r  <= ch1;
      end
   end

   // ----------------------------------------------------------------
   // slave mode counting
   // ----------------------------------------------------------------
   logic step, up, restart;
   always_comb begin
      step    = 1'b0;
      up      = 1'b1;
      restart = 1'b0;
      case (smcfg_r.slave_mode_control)
         TSM_SMC_DISABLE: step = cen_r;                                  // R4
         TSM_SMC_QUAD0: begin
            step = cen_r && ch0_edge;                                    // R5
            up   = ch0 ^ ch1;
         end
         TSM_SMC_QUAD1: begin
            step = cen_r && ch1_edge;                                    // R6
            up   = ch0 ~^ ch1;
         end
         TSM_SMC_QUAD2: begin
            step = cen_r && (ch0_edge || ch1_edge);                      // R7
            up   = ch0_edge ? (ch0 ^ ch1) : (ch0 ~^ ch1);
         end
         TSM_SMC_RESTART: begin
            step    = cen_r;
            restart = trig_rise;                                         // R8
         end
         TSM_SMC_PAUSE:   step = cen_r && trig_lvl;                      // R9
         TSM_SMC_EVENT:   step = cen_r;
         TSM_SMC_EXTCLK0: step = cen_r && trig_rise;                     // R11
         default:         step = 1'b0;
      endcase
   end

   logic wrap, upd_evt;
   assign wrap    = step && (up ? (cnt_r == reload_r) : (cnt_r == 16'h0000));
   assign upd_evt = restart || wrap;

   // ----------------------------------------------------------------
   // apb decode
   // ----------------------------------------------------------------
   logic acc, wr, mapped;
   assign acc    = psel && penable && pready;
   assign wr     = acc && pwrite;
   assign mapped = (paddr == TSM_CTRL_OFS) || (paddr == TSM_SMCFG_OFS) ||
                   (paddr == TSM_DIE_OFS) || (paddr == TSM_FLAG_OFS) ||
                   (paddr == TSM_CNT_OFS) || (paddr == TSM_RELOAD_OFS);

   always_ff @(posedge mclk or negedge rst_n) begin
      if (!rst_n) begin
         cnt_r <= TSM_REG_RST[15:0];
      end else if (wr && paddr == TSM_CNT_OFS) begin
         cnt_r <= pwdata[15:0];
      end else if (restart) begin
         cnt_r <= 16'h0000;                                              // R8
      end else if (step) begin
         if (up) begin
            cnt_r <= wrap ? 16'h0000 : cnt_r + 16'h0001;
         end else begin
            cnt_r <= wrap ? reload_r : cnt_r - 16'h0001;
         end
      end
   end

   // event mode start wins over a software write in the same cycle
   always_ff @(posedge mclk or negedge rst_n) begin
      if (!rst_n) begin
         cen_r <= 1'b0;
      end else if (smcfg_r.slave_mode_control == TSM_SMC_EVENT && trig_rise) begin
         cen_r <= 1'b1;                                                  // R10
      end else if (wr && paddr == TSM_CTRL_OFS) begin
         cen_r <= pwdata[TSM_CEN_BIT];
      end
   end

   // R16: reserved bits are not stored and read as zero
   always_ff @(posedge mclk or negedge rst_n) begin
      if (!rst_n) begin
         smcfg_r  <= tsm_smcfg_t'(TSM_REG_RST[15:0]);
         die_r    <= TSM_REG_RST;                                        // R14
         reload_r <= TSM_RELOAD_RST;
      end else if (wr) begin
         if (paddr == TSM_SMCFG_OFS) begin
            smcfg_r       <= tsm_smcfg_t'(pwdata[15:0]);
            smcfg_r.rsvd3 <= 1'b0;
         end
         if (paddr == TSM_DIE_OFS) begin
            die_r <= pwdata & TSM_DIE_MASK;                              // R12 R13 R14
         end
         if (paddr == TSM_RELOAD_OFS) begin
            reload_r <= pwdata[15:0];
         end
      end
   end

   // ----------------------------------------------------------------
   // flags, interrupt and dma requests
   // ----------------------------------------------------------------
   logic [31:0] flag_set;
   always_comb begin
      flag_set                  = 32'h0000_0000;
      flag_set[TSM_UPD_FLAG]    = upd_evt;                               // R18
      flag_set[4:1]             = chan_ev.capture | chan_ev.compare;
      flag_set[5]               = commutation_evt;
      flag_set[TSM_TRG_FLAG]    = trig_evt;
      flag_set[7]               = break_evt;
      flag_set[12:TSM_OVC_LSB]  = chan_ev.capture & flags_r[4:1];        // R19
   end

   // a set in the clearing cycle survives the write
   always_ff @(posedge mclk or negedge rst_n) begin
      if (!rst_n) begin
         flags_r <= TSM_REG_RST;
      end else if (wr && paddr == TSM_FLAG_OFS) begin
         flags_r <= ((flags_r & pwdata) | flag_set) & TSM_FLAG_MASK;     // R15
      end else begin
         flags_r <= (flags_r | flag_set) & TSM_FLAG_MASK;
      end
   end

   always_ff @(posedge mclk or negedge rst_n) begin
      if (!rst_n) begin
         irq_req        <= 1'b0;
         dma_req        <= 7'h00;
         trigger_output <= 1'b0;
         count_value    <= 16'h0000;
      end else begin
         irq_req        <= |(flags_r[7:0] & die_r[7:0]);                 // R22 R13
         dma_req        <= flag_set[6:0] & die_r[14:TSM_DEN_LSB];        // R22 R12
         trigger_output <= smcfg_r.master_slave_sync ? trig_evt : upd_evt; // R1
         count_value    <= cnt_r;
      end
   end

   // ----------------------------------------------------------------
   // apb answer: one wait state, data from a register
   // ----------------------------------------------------------------
   always_ff @(posedge mclk or negedge rst_n) begin
      if (!rst_n) begin
         pready  <= 1'b0;
         prdata  <= 32'h0000_0000;
         pslverr <= 1'b0;
      end else begin
         pready  <= psel && penable && !pready;
         pslverr <= psel && penable && !pready && !mapped;
         prdata  <= 32'h0000_0000;
         if (psel && penable && !pready && !pwrite) begin
            case (paddr)
               TSM_CTRL_OFS:   prdata <= {31'h0, cen_r};
               TSM_SMCFG_OFS:  prdata <= {16'h0000, smcfg_r};
               TSM_DIE_OFS:    prdata <= die_r;
               TSM_FLAG_OFS:   prdata <= flags_r;
               TSM_CNT_OFS:    prdata <= {16'h0000, cnt_r};
               TSM_RELOAD_OFS: prdata <= {16'h0000, reload_r};
               default:        prdata <= 32'h0000_0000;
            endcase
         end
      end
   end

   // ----------------------------------------------------------------
   // checks
   // ----------------------------------------------------------------
   logic cnt_wr;
   assign cnt_wr = wr && paddr == TSM_CNT_OFS;

   restart_clear_a: assert property (@(posedge mclk) disable iff (!rst_n) // R8
      (smcfg_r.slave_mode_control == TSM_SMC_RESTART && trig_rise && !cnt_wr)
      |=> (cnt_r == 16'h0000) && flags_r[TSM_UPD_FLAG])
      else $error("restart did not clear counter");
   pause_hold_a: assert property (@(posedge mclk) disable iff (!rst_n) // R9
      (smcfg_r.slave_mode_control == TSM_SMC_PAUSE && !trig_lvl && !cnt_wr)
      |=> cnt_r == $past(cnt_r))
      else $error("counter moved while paused");
   event_start_a: assert property (@(posedge mclk) disable iff (!rst_n) // R10
      (smcfg_r.slave_mode_control == TSM_SMC_EVENT && trig_rise) |=> cen_r)
      else $error("event mode did not start counter");
   free_count_a: assert property (@(posedge mclk) disable iff (!rst_n) // R4
      (smcfg_r.slave_mode_control == TSM_SMC_DISABLE && cen_r && !cnt_wr
       && cnt_r != reload_r) |=> cnt_r == $past(cnt_r) + 16'h0001)
      else $error("counter did not step on timer clock");
   upd_flag_a: assert property (@(posedge mclk) disable iff (!rst_n) // R18
      upd_evt |=> flags_r[TSM_UPD_FLAG])
      else $error("update flag not set");
   overcap_a: assert property (@(posedge mclk) disable iff (!rst_n) // R19
      (chan_ev.capture[0] && flags_r[1]) |=> flags_r[TSM_OVC_LSB])
      else $error("over-capture flag not set");
   trig_both_a: assert property (@(posedge mclk) disable iff (!rst_n) // R20
      (smcfg_r.slave_mode_control == TSM_SMC_PAUSE && trig_fall)
      |=> flags_r[TSM_TRG_FLAG])
      else $error("falling edge in pause made no trigger event");
   sync_out_a: assert property (@(posedge mclk) disable iff (!rst_n) // R1
      (smcfg_r.master_slave_sync && trig_evt) |=> trigger_output)
      else $error("trigger not propagated");
   dma_trig_a: assert property (@(posedge mclk) disable iff (!rst_n) // R12
      (trig_evt && die_r[14]) |=> dma_req[6] ##1 !dma_req[6] || $past(trig_evt))
      else $error("trigger dma request missing");
   irq_level_a: assert property (@(posedge mclk) disable iff (!rst_n) // R22
      (|(flags_r[7:0] & die_r[7:0])) |=> irq_req)
      else $error("interrupt not raised");
   apb_wait_a: assert property (@(posedge mclk) disable iff (!rst_n)
      (psel && !penable) |=> !pready ##1 (pready || !penable))
      else $error("apb answer timing wrong");

   restart_cov: cover property (@(posedge mclk) disable iff (!rst_n)
      smcfg_r.slave_mode_control == TSM_SMC_RESTART && trig_rise);
   quad_cov: cover property (@(posedge mclk) disable iff (!rst_n)
      smcfg_r.slave_mode_control == TSM_SMC_QUAD2 && step && !up);
   event_cov: cover property (@(posedge mclk) disable iff (!rst_n)
      smcfg_r.slave_mode_control == TSM_SMC_EVENT && trig_rise ##1 cen_r);

endmodule

// ==== dv/tsm_trig_src.sv ====
// trigger source model standing in for the other timers
`timescale 1ns/100ps
module tsm_trig_src (
   // clock
   input  wire logic       mclk,
   // trigger levels
   output logic [3:0]      internal_trigger
);
   initial internal_trigger = 4'h0;
   // held long enough to pass the 3-flop sync and accept stage
   task automatic pulse(input int n);
      internal_trigger[n] <= 1'b1;
      repeat (6) @(posedge mclk);
      internal_trigger[n] <= 1'b0;
      repeat (6) @(posedge mclk);
   endtask
endmodule

// ==== dv/tb_top.sv ====
// self-checking bench of the timer slave-mode controller
`timescale 1ns/100ps
module tb_top;
   import tsm_pkg::*;
   logic         mclk = 1'b0, rst_n = 1'b0, psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
   logic [7:0]   paddr = 8'h00;
   logic [31:0]  pwdata = 32'h0, prdata, rd_v;
   logic         pready, pslverr, trigger_output, irq_req, err;
   logic [3:0]   itrg;
   logic [6:0]   dma_req;
   logic [15:0]  count_value;
   tsm_chan_ev_t chan_ev = '0;
   logic         ch0_in = 1'b0, ch1_in = 1'b0, brk = 1'b0, cmt = 1'b0;
   // one full forward quadrature cycle as {chan0, chan1}
   logic [1:0]   qs [4] = '{2'h2, 2'h3, 2'h1, 2'h0};
   int           failures = 0, n_tests = 0, cyc = 0, n_trigger_output = 0, n_dma = 0;
   always #5 mclk = ~mclk;
   tsm_trig_src tsm_trig_src_i (.mclk(mclk), .internal_trigger(itrg));
   tsm_slave_ctrl tsm_slave_ctrl_i (.mclk, .rst_n, .psel, .penable, .pwrite, .paddr,
      .pwdata, .pready, .prdata, .pslverr, .internal_trigger(itrg),
      .chan0_filtered_in(ch0_in), .chan1_filtered_in(ch1_in), .ext_trigger_pin(1'b0),
      .chan_ev, .break_evt(brk), .commutation_evt(cmt), .trigger_output,
      .irq_req, .dma_req, .count_value);
   // ----------------------------------------------------------------
   // tasks
   // ----------------------------------------------------------------
   task automatic print_verdict();
      $display("checks %0d mismatches %0d", n_tests, failures);
      if (failures == 0 && n_tests > 0) begin
         $display("STATUS OK");
      end else begin
         $display("STATUS NOT OK");
      end
      $finish;
   endtask
   task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
      n_tests++;
      if (g !== e) begin
         failures++;
         $display("BAD %s exp %h got %h", nm, e, g);
      end
   endtask
   task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
      @(posedge mclk);
      psel <= 1'b1;
      pwrite <= w;
      paddr <= a;
      pwdata <= d;
      @(posedge mclk);
      penable <= 1'b1;
      do begin
         @(posedge mclk);
      end while (pready !== 1'b1);
      rd_v = prdata;
      err = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
   endtask
   task automatic rd(input string nm, input logic [7:0] a, input logic [31:0] e);
      apb(1'b0, a, 32'h0);
      chk(nm, e, rd_v);
   endtask
   task automatic quad(input string nm, input logic [31:0] mode, input logic [31:0] e);
      apb(1'b1, TSM_SMCFG_OFS, mode);
      apb(1'b1, TSM_CNT_OFS, 32'h0);
      for (int i = 0; i < 4; i++) begin
         {ch0_in, ch1_in} <= qs[i];
         repeat (6) @(posedge mclk);
      end
      rd(nm, TSM_CNT_OFS, e);
   endtask
   // bounded run: a hang counts as a mismatch
   always @(posedge mclk) begin
      cyc++;
      n_trigger_output += int'(trigger_output === 1'b1);
      n_dma += int'(dma_req[0] === 1'b1);
      if (cyc == 20000) begin
         failures++;
         print_verdict();
      end
   end
   // ----------------------------------------------------------------
   // tests
   // ----------------------------------------------------------------
   initial begin
      repeat (4) @(posedge mclk);
      rst_n <= 1'b1;
      rd("die_rst", TSM_DIE_OFS, 32'h0);
      rd("flag_rst", TSM_FLAG_OFS, 32'h0);
      apb(1'b1, TSM_DIE_OFS, 32'h0000_7fff);
      rd("die_mask", TSM_DIE_OFS, 32'h0000_7fff);
      rd("unmapped", 8'h40, 32'h0);
      chk("slverr", 32'h1, {31'h0, err});
      $display("test registers done");
      apb(1'b1, TSM_DIE_OFS, 32'h0000_4101);
      apb(1'b1, TSM_CTRL_OFS, 32'h1);
      apb(1'b1, TSM_SMCFG_OFS, 32'h0000_0004);
      tsm_trig_src_i.pulse(0);
      chk("irq_on", 32'h1, {31'h0, irq_req});
      chk("trigger_output_upd", 32'h1, n_trigger_output);
      chk("dma_upd", 32'h1, n_dma);
      rd("restart_flags", TSM_FLAG_OFS, 32'h0000_0041);
      apb(1'b1, TSM_FLAG_OFS, 32'h0);
      rd("flags_clr", TSM_FLAG_OFS, 32'h0);
      chk("irq_off", 32'h0, {31'h0, irq_req});
      $display("test restart done");
      apb(1'b1, TSM_SMCFG_OFS, 32'h0000_0087);
      apb(1'b1, TSM_CNT_OFS, 32'h0);
      repeat (3) tsm_trig_src_i.pulse(0);
      rd("extclk_cnt", TSM_CNT_OFS, 32'h3);
      chk("trigger_output_sync", 32'h4, n_trigger_output);
      apb(1'b1, TSM_SMCFG_OFS, 32'h0000_0005);
      apb(1'b1, TSM_CNT_OFS, 32'h0);
      repeat (10) @(posedge mclk);
      rd("pause_cnt", TSM_CNT_OFS, 32'h0);
      tsm_trig_src_i.pulse(0);
      rd("pause_run", TSM_CNT_OFS, 32'h6);
      apb(1'b1, TSM_SMCFG_OFS, 32'h0000_0006);
      apb(1'b1, TSM_CTRL_OFS, 32'h0);
      tsm_trig_src_i.pulse(0);
      rd("event_cen", TSM_CTRL_OFS, 32'h1);
      quad("quad_ch0", 32'h0000_0001, 32'h2);
      quad("quad_ch1", 32'h0000_0002, 32'h2);
      quad("quad_both", 32'h0000_0003, 32'h4);
      $display("test modes done");
      apb(1'b1, TSM_FLAG_OFS, 32'h0);
      repeat (2) begin
         @(posedge mclk);
         chan_ev.capture <= 4'h1;
         @(posedge mclk);
         chan_ev.capture <= 4'h0;
      end
      rd("overcapture", TSM_FLAG_OFS, 32'h0000_0202);
      apb(1'b1, TSM_FLAG_OFS, 32'h0);
      brk <= 1'b1;
      cmt <= 1'b1;
      @(posedge mclk);
      brk <= 1'b0;
      cmt <= 1'b0;
      rd("brk_cmt", TSM_FLAG_OFS, 32'h0000_00a0);
      $display("test capture done");
      print_verdict();
   end
endmodule
